// ### hdl/postdiv_pkg.sv
// Constants for the synthesizer post-divider block: register map, field layout, reset values.
// Assumes a 32-bit Avalon-MM slave with byte addresses, each register on one aligned word.
// Function
// R1: Shape field all ones selects frame pulse output instead of a clock.
// R2: Otherwise the full 24-bit word is the ratio; output is 50% duty.
// R3: Software keeps the regular-clock ratio at or below the maximum.
// R4: Frame pulses are spaced by the period field count of related clocks.
// R5: Divider B select: 00 A, 10 C, 11 D; 01 reserved.
// R6: Each frame pulse lasts exactly one related-clock period.
// R7: Software never selects a divider as its own related clock.
// R8: Polarity bit 0 gives active-high pulse, 1 gives inverted pulse.
// R9: Type bit 0 centres pulse on boundary; 1 aligns boundary to pulse edge.
// R10: Any config write restarts that divider's counting from the new settings.
package postdiv_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices and byte addresses
  localparam logic [7:0]  IDX_DIV_B     = 8'hA7;
  localparam logic [7:0]  IDX_DIV_C     = 8'hAA;
  localparam logic [7:0]  IDX_STATUS    = 8'hB0;
  localparam int          ADDR_W        = 10;
  localparam logic [9:0]  ADDR_DIV_B    = {IDX_DIV_B, 2'b00};
  localparam logic [9:0]  ADDR_DIV_C    = {IDX_DIV_C, 2'b00};
  localparam logic [9:0]  ADDR_STATUS   = {IDX_STATUS, 2'b00};

  ////////////////////////////////////////////////////////////////////////////////
  // Field layout of a divider configuration word
  localparam int          CFG_W         = 24;
  localparam int          SHAPE_HI      = 23;
  localparam int          SHAPE_LO      = 20;
  localparam int          TYPE_BIT      = 19;
  localparam int          POL_BIT       = 18;
  localparam int          SEL_HI        = 17;
  localparam int          SEL_LO        = 16;
  localparam int          PERIOD_HI     = 15;
  localparam int          PERIOD_LO     = 0;
  localparam int          PERIOD_W      = 16;
  localparam logic [3:0]  FRAME_CODE    = 4'hF;
  localparam logic [23:0] MAX_RATIO     = 24'hEFFFFF;
  localparam logic [23:0] CFG_RESET     = 24'h000000;

  ////////////////////////////////////////////////////////////////////////////////
  // Related clock codes, also the index into the sibling level vector
  localparam logic [1:0]  SEL_A         = 2'h0;
  localparam logic [1:0]  SEL_B         = 2'h1;
  localparam logic [1:0]  SEL_C         = 2'h2;
  localparam logic [1:0]  SEL_D         = 2'h3;

endpackage

// ### hdl/postdiv_channel.sv
// One post-divider: regular 50% clock or frame pulse timed by a sibling divider.
// Assumes sibling levels are flip-flop outputs on ref_clk_i; no synchroniser needed.
`timescale 1ns/1ps
module postdiv_channel #(
  parameter logic [1:0] SELF_CODE = 2'h1
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [23:0] cfg_i,
  input  wire logic        restart_i,
  input  wire logic [3:0]  rel_i,
  output logic             clk_o
);

  logic        frame_mode;
  logic [1:0]  sel;
  logic        rel_ok;
  logic        rel_lvl;
  logic        rel_prev_ff;
  logic        rise;
  logic        fall;
  logic        last;
  logic [15:0] period;
  logic [15:0] rise_cnt_ff;
  logic        pulse_ff;
  logic [23:0] cnt_ff;
  logic [23:0] nxt_cnt;
  logic [23:0] hi_len;
  logic [24:0] half_sum;

  assign frame_mode = (cfg_i[postdiv_pkg::SHAPE_HI:postdiv_pkg::SHAPE_LO]
                       == postdiv_pkg::FRAME_CODE);                         // [R1]
  assign sel        = cfg_i[postdiv_pkg::SEL_HI:postdiv_pkg::SEL_LO];
  // Own code is the reserved one: pulse then stays inactive
  assign rel_ok     = (sel != SELF_CODE);                                   // [R5]
  assign rel_lvl    = rel_ok & rel_i[sel];                                  // [R5]
  assign period     = cfg_i[postdiv_pkg::PERIOD_HI:postdiv_pkg::PERIOD_LO];
  assign rise       = rel_lvl & ~rel_prev_ff;
  assign fall       = ~rel_lvl & rel_prev_ff;
  assign last       = ({1'b0, rise_cnt_ff} + 17'h00001) == {1'b0, period}; // [R4]

  // Odd ratios get the longer half high, closest to 50%
  assign half_sum   = {1'b0, cfg_i} + 25'h0000001;
  assign hi_len     = half_sum[24:1];                                       // [R2]
  assign nxt_cnt    = (cnt_ff + 24'h000001 >= cfg_i) ? 24'h000000
                                                     : cnt_ff + 24'h000001; // [R2]

  ////////////////////////////////////////////////////////////////////////////////
  // Related clock edge detection
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rel_prev_ff <= 1'b0;
    else
      rel_prev_ff <= rel_lvl;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame counting: boundary is the related rising edge that ends a frame
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rise_cnt_ff <= 16'h0000;
    else if (restart_i || !frame_mode)
      rise_cnt_ff <= 16'h0000;                                              // [R10]
    else if (rise)
      rise_cnt_ff <= last ? 16'h0000 : rise_cnt_ff + 16'h0001;             // [R4]
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pulse_ff <= 1'b0;
    else if (restart_i || !frame_mode || period == 16'h0000)
      pulse_ff <= 1'b0;                                                     // [R10]
    else if (cfg_i[postdiv_pkg::TYPE_BIT])
    begin
      // Edge type: rises on the boundary, ends one related period later
      if (rise)
        pulse_ff <= last;                                                   // [R9] [R6]
    end
    else
    begin
      // Centred type: half a period either side of the boundary
      if (fall)
        pulse_ff <= last;                                                   // [R9] [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Regular divider counter; ratios 0 and 1 hold the output low
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      cnt_ff <= 24'h000000;
    else if (restart_i || frame_mode)
      cnt_ff <= 24'h000000;                                                 // [R10]
    else
      cnt_ff <= nxt_cnt;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      clk_o <= 1'b0;
    else if (frame_mode)
      clk_o <= pulse_ff ^ cfg_i[postdiv_pkg::POL_BIT];                      // [R8]
    else if (restart_i || cfg_i < 24'h000002)
      clk_o <= 1'b0;
    else
      clk_o <= (nxt_cnt < hi_len);                                          // [R2]
  end

endmodule

// ### hdl/synth_postdiv_frame_pulse.sv
// Top of the post-divider block: Avalon-MM register slave plus dividers B and C.
// Assumes sibling A and D outputs arrive as levels from logic on ref_clk_i.
`timescale 1ns/1ps
module synth_postdiv_frame_pulse (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [9:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic        rel_a_i,
  input  wire logic        rel_d_i,
  output logic             waitrequest_o,
  output logic [31:0]      readdata_o,
  output logic             div_b_clk_o,
  output logic             div_c_clk_o
);

  logic [23:0] divider_b_ratio_ff;
  logic [23:0] divider_c_ratio_ff;
  logic        restart_b_ff;
  logic        restart_c_ff;
  logic        accept;
  logic        wr_b;
  logic        wr_c;
  logic [3:0]  rel_vec;
  logic [31:0] nxt_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the access lands on the low-waitrequest edge
  assign accept = (read_i | write_i) & ~waitrequest_o;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      waitrequest_o <= 1'b1;
    else
      waitrequest_o <= ~((read_i | write_i) & waitrequest_o);
  end

  assign wr_b = accept & write_i & (address_i == postdiv_pkg::ADDR_DIV_B);
  assign wr_c = accept & write_i & (address_i == postdiv_pkg::ADDR_DIV_C);

  function automatic logic [23:0] merge(input logic [23:0] old_v,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [23:0] v;
    v = old_v;
    for (int i = 0; i < 3; i++)
      if (be[i])
        v[i*8 +: 8] = wd[i*8 +: 8];
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers; the limit on regular ratios is left to software
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      divider_b_ratio_ff <= postdiv_pkg::CFG_RESET;
    else if (wr_b)
      divider_b_ratio_ff <= merge(divider_b_ratio_ff, writedata_i, byteenable_i);
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      divider_c_ratio_ff <= postdiv_pkg::CFG_RESET;
    else if (wr_c)
      divider_c_ratio_ff <= merge(divider_c_ratio_ff, writedata_i, byteenable_i);
  end

  // Restart lines up with the new value reaching the divider
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      restart_b_ff <= 1'b0;
      restart_c_ff <= 1'b0;
    end
    else
    begin
      restart_b_ff <= wr_b;                                                 // [R10]
      restart_c_ff <= wr_c;                                                 // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data; unmapped addresses read zero and ignore writes
  always_comb
  begin
    nxt_rdata = 32'h00000000;
    unique case (address_i)
      postdiv_pkg::ADDR_DIV_B:  nxt_rdata = {8'h00, divider_b_ratio_ff};
      postdiv_pkg::ADDR_DIV_C:  nxt_rdata = {8'h00, divider_c_ratio_ff};
      postdiv_pkg::ADDR_STATUS: nxt_rdata = {28'h0000000,
        divider_c_ratio_ff[postdiv_pkg::SHAPE_HI:postdiv_pkg::SHAPE_LO]
          == postdiv_pkg::FRAME_CODE,
        divider_b_ratio_ff[postdiv_pkg::SHAPE_HI:postdiv_pkg::SHAPE_LO]
          == postdiv_pkg::FRAME_CODE,
        div_c_clk_o, div_b_clk_o};
      default:                  nxt_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      readdata_o <= 32'h00000000;
    else if ((read_i | write_i) & waitrequest_o)
      readdata_o <= read_i ? nxt_rdata : 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Dividers; each takes the other's output as a possible related clock
  // Own-code selection is forbidden to software and treated as reserved
  assign rel_vec = {rel_d_i, div_c_clk_o, div_b_clk_o, rel_a_i};           // [R7]

  postdiv_channel #(
    .SELF_CODE (postdiv_pkg::SEL_B)
  ) u_div_b (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .cfg_i     (divider_b_ratio_ff),
    .restart_i (restart_b_ff),
    .rel_i     (rel_vec),
    .clk_o     (div_b_clk_o)
  );

  postdiv_channel #(
    .SELF_CODE (postdiv_pkg::SEL_C)
  ) u_div_c (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .cfg_i     (divider_c_ratio_ff),
    .restart_i (restart_c_ff),
    .rel_i     (rel_vec),
    .clk_o     (div_c_clk_o)
  );

endmodule

// ### test/postdiv_monitor.sv
// Port checker for the post-divider top.
// Assumes the bench drives related clock A with an 8-cycle period.
`timescale 1ns/1ps
module postdiv_monitor (
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic [9:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0]  byteenable_i,
  input wire logic        waitrequest_o,
  input wire logic [31:0] readdata_o,
  input wire logic        div_b_clk_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////
  // Shadow of the B word; partial writes spoil it on purpose
  logic [23:0] cfg_ff;
  logic [7:0]  age_ff;
  wire         wr_b = write_i && !waitrequest_o && address_i == postdiv_pkg::ADDR_DIV_B;
  wire         frm = cfg_ff[23:20] == 4'hF && age_ff > 8'h10;
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
    if (!reset_n_i)
      cfg_ff <= 24'h000000;
    else if (wr_b)
      cfg_ff <= byteenable_i[2:0] == 3'h7 ? writedata_i[23:0] : 24'h000001;
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
    if (!reset_n_i)
      age_ff <= 8'h00;
    else if (wr_b)
      age_ff <= 8'h00;
    else if (age_ff != 8'hFF)
      age_ff <= age_ff + 8'h01;
  ////////////////////////////////////////////////////////////
  sequence s_high8;
    div_b_clk_o [*8] ##1 !div_b_clk_o;
  endsequence
  sequence s_low8;
    !div_b_clk_o [*8] ##1 div_b_clk_o;
  endsequence
  property p_wait_ans;
    (read_i || write_i) && waitrequest_o |=> !waitrequest_o;
  endproperty
  property p_wait_one;
    !waitrequest_o |=> waitrequest_o;
  endproperty
  property p_rd_hold;
    waitrequest_o && !read_i && !write_i |=> $stable(readdata_o);
  endproperty
  property p_odd;
    !frm && age_ff > 8'h10 && cfg_ff == 24'h000005 && $rose(div_b_clk_o)
      |-> div_b_clk_o [*3] ##1 !div_b_clk_o [*2] ##1 div_b_clk_o;
  endproperty
  property p_idle;
    frm && cfg_ff[15:0] == 16'h0000 |-> div_b_clk_o == cfg_ff[18];
  endproperty
  property p_rsv;
    frm && cfg_ff[17:16] == 2'h1 |-> div_b_clk_o == cfg_ff[18];
  endproperty
  property p_width;
    frm && cfg_ff[19:16] == 4'h8 && $rose(div_b_clk_o) |-> s_high8;
  endproperty
  property p_inv;
    frm && cfg_ff[18:16] == 3'h4 && $fell(div_b_clk_o) |-> s_low8;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  a_rd_hold: assert property (p_rd_hold) else $error("readdata moved while idle");
  a_odd: assert property (p_odd) else $error("odd ratio shape wrong");
  a_idle: assert property (p_idle) else $error("idle level wrong");
  a_rsv: assert property (p_rsv) else $error("reserved select not idle");
  a_width: assert property (p_width) else $error("pulse width wrong");
  a_inv: assert property (p_inv) else $error("inverted pulse wrong");
endmodule

// ### test/tb_top.sv
// Bench for the post-divider top: Avalon register access and output timing.
// Assumes the monitor is compiled first; sibling clocks A and D come from here.
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [9:0]  address_i = 10'h000;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic [31:0] writedata_i = 32'h00000000;
  logic [3:0]  byteenable_i = 4'hF;
  logic        rel_a_i = 1'b0;
  logic        rel_d_i = 1'b0;
  logic        waitrequest_o;
  logic [31:0] readdata_o;
  logic        div_b_clk_o;
  logic        div_c_clk_o;
  logic [31:0] q;
  logic        ra;
  int          cyc = 0;
  int          bad_count = 0;
  int          check_count = 0;
  int          t1, t2, w;
  synth_postdiv_frame_pulse synth_postdiv_frame_pulse_i (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(byteenable_i), .rel_a_i(rel_a_i),
    .rel_d_i(rel_d_i), .waitrequest_o(waitrequest_o), .readdata_o(readdata_o),
    .div_b_clk_o(div_b_clk_o), .div_c_clk_o(div_c_clk_o));
  always #5 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////////////////////////
  // Sibling A: period 8, sibling D: period 12; also the hang limit
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    rel_a_i <= cyc[2];
    rel_d_i <= (cyc % 12) < 6;
    if (cyc == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low at an edge
  task automatic acc(input logic wr, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    read_i <= !wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= be;
    @(posedge ref_clk_i);
    while (waitrequest_o !== 1'b0)
      @(posedge ref_clk_i);
    rd = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  // Next low-to-high of an output, then the length of its high run
  task automatic rise(input bit c, output int t, output int wd);
    logic p, v;
    v = 1'b1;
    wd = 0;
    repeat (400)
    begin
      p = v;
      @(posedge ref_clk_i);
      v = c ? div_c_clk_o : div_b_clk_o;
      if (p === 1'b0 && v === 1'b1)
        break;
    end
    t = cyc;
    ra = rel_a_i;
    while (v === 1'b1 && wd < 400)
    begin
      wd++;
      @(posedge ref_clk_i);
      v = c ? div_c_clk_o : div_b_clk_o;
    end
  endtask
  // First rise after restart may be partial, so it is skipped
  task automatic run(input bit c, input logic [23:0] d, input int ew, input int ep);
    int x;
    acc(1'b1, c ? postdiv_pkg::ADDR_DIV_C : postdiv_pkg::ADDR_DIV_B, {8'h00, d}, 4'hF, q);
    rise(c, t1, w);
    rise(c, t1, w);
    rise(c, t2, x);
    chk(w, ew);
    chk(t2 - t1, ep);
    if (d[23:16] == 8'hF8 || d[23:16] == 8'hF0)
      chk(ra, d[19]);
    $display("test run %h done", d);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    acc(1'b0, postdiv_pkg::ADDR_DIV_B, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    acc(1'b0, postdiv_pkg::ADDR_DIV_C, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    acc(1'b1, postdiv_pkg::ADDR_DIV_B, 32'hFF123456, 4'hF, q);
    acc(1'b1, postdiv_pkg::ADDR_DIV_B, 32'h000000AB, 4'h1, q);
    acc(1'b0, postdiv_pkg::ADDR_DIV_B, 32'h0, 4'hF, q);
    chk(q, 32'h001234AB);
    acc(1'b1, 10'h3FC, 32'h5A5A5A5A, 4'hF, q);
    acc(1'b0, 10'h3FC, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    $display("test registers done");
    run(1'b0, 24'h000005, 3, 5);
    run(1'b1, 24'h00000A, 5, 10);
    run(1'b0, 24'hF80003, 8, 24);
    run(1'b0, 24'hF00003, 8, 24);
    run(1'b0, 24'hF30003, 12, 36);
    run(1'b0, 24'hF20002, 10, 20);
    run(1'b0, 24'hFC0003, 16, 24);
    // Let the low pulse finish; a write now would cut it short
    repeat (8) @(posedge ref_clk_i);
    acc(1'b0, postdiv_pkg::ADDR_STATUS, 32'h0, 4'hF, q);
    chk(q & 32'hC, 32'h4);
    run(1'b0, 24'hF80003, 8, 24);
    // Rewrite lands mid-frame: counting restarts, next pulse 40 cycles on, not 24
    t1 = t2;
    repeat (4) @(posedge ref_clk_i);
    acc(1'b1, postdiv_pkg::ADDR_DIV_B, 32'h00F80003, 4'hF, q);
    rise(1'b0, t2, w);
    chk(t2 - t1, 40);
    chk(w, 8);
    acc(1'b1, postdiv_pkg::ADDR_DIV_B, 32'h00F50003, 4'hF, q);
    repeat (40) @(posedge ref_clk_i);
    chk(div_b_clk_o, 32'h1);
    acc(1'b1, postdiv_pkg::ADDR_DIV_B, 32'h00F80000, 4'hF, q);
    repeat (40) @(posedge ref_clk_i);
    chk(div_b_clk_o, 32'h0);
    run(1'b1, 24'hF80003, 8, 24);
    acc(1'b0, postdiv_pkg::ADDR_STATUS, 32'h0, 4'hF, q);
    chk(q & 32'hC, 32'hC);
    acc(1'b1, postdiv_pkg::ADDR_DIV_C, 32'h00F60003, 4'hF, q);
    repeat (40) @(posedge ref_clk_i);
    chk(div_c_clk_o, 32'h1);
    $display("test idle levels done");
    end_of_test();
  end
endmodule
bind synth_postdiv_frame_pulse postdiv_monitor postdiv_monitor_i (.ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
  .writedata_i(writedata_i), .byteenable_i(byteenable_i), .waitrequest_o(waitrequest_o),
  .readdata_o(readdata_o), .div_b_clk_o(div_b_clk_o));
